// ### include/pcs_regs.svh
// Register offsets, field positions and reset values of the configuration space
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
// Offsets into the 4096-byte configuration space
`define PCS_OFF_ID        12'h000
`define PCS_OFF_CMD       12'h004
`define PCS_OFF_CLASS     12'h008
`define PCS_OFF_MISC      12'h00c
`define PCS_OFF_BAR0      12'h010
`define PCS_OFF_CAPPTR    12'h034
`define PCS_OFF_INTR      12'h03c
`define PCS_OFF_VPD       12'h090
`define PCS_OFF_PM_HDR    12'h098
`define PCS_OFF_PM_CSR    12'h09c
`define PCS_OFF_MSI_HDR   12'h0a0
`define PCS_OFF_MSI_ALO   12'h0a4
`define PCS_OFF_MSI_AHI   12'h0a8
`define PCS_OFF_MSI_DATA  12'h0ac
`define PCS_OFF_MSIX_HDR  12'h0b0
`define PCS_OFF_MSIX_TBL  12'h0b4
`define PCS_OFF_MSIX_PEND 12'h0b8
`define PCS_OFF_PCIE_HDR  12'h0d0
`define PCS_OFF_PCIE_DEV  12'h0d8
`define PCS_OFF_PCIE_LNK  12'h0e0
`define PCS_OFF_AER_UNC   12'h104
`define PCS_OFF_AER_COR   12'h110
`define PCS_OFF_AER_LOG0  12'h11c
`define PCS_OFF_AER_LOG1  12'h120
`define PCS_OFF_AER_LOG2  12'h124
`define PCS_OFF_AER_LOG3  12'h128
`define PCS_OFF_IMASK     12'h180
`define PCS_OFF_RETRY_CTL 12'h188
// Legacy status bit positions
`define PCS_ST_DPE        15
`define PCS_ST_SSE        14
`define PCS_ST_RMA        13
`define PCS_ST_RTA        12
`define PCS_ST_STA        11
`define PCS_ST_MDPE       8
`define PCS_ST_CAPL       4
`define PCS_ST_W1C_MASK   16'hf900
`define PCS_CMD_WMASK     16'h0547
// Capability identifiers and chain links
`define PCS_CAP_PTR       8'h98
`define PCS_ID_PM         8'h01
`define PCS_ID_MSI        8'h05
`define PCS_ID_MSIX       8'h11
`define PCS_ID_PCIE       8'h10
`define PCS_ID_VPD        8'h03
`define PCS_PM_NEXT       8'hd0
`define PCS_MSI_NEXT      8'hd0
`define PCS_MSIX_NEXT     8'ha0
`define PCS_VPD_NEXT      8'h00
`define PCS_PCIE_NEXT_RST 8'h00
`define PCS_PCIE_CAPS     16'h0001
`define PCS_HDR_TYPE0     8'h00
// Local control registers, field positions and reset values
`define PCS_IMASK_PST     8
`define PCS_IMASK_RST     32'h0000_0100
`define PCS_RETRY_BIT     2
`define PCS_RETRY_CTL_RST 32'h0000_0004
`endif

// ### include/pcs_pkg.sv
// Types shared by the configuration space design files
package pcs_pkg;
  // Configuration request from the link side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        type0;
    logic [2:0]  func;
    logic [11:0] offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcs_cfg_req_t;
  // Internal bus request, always a whole word
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] offset;
    logic [31:0] wdata;
  } pcs_ib_req_t;
  // Answer to either port
  typedef struct packed {
    logic        valid;
    logic        retry;
    logic        unsup;
    logic [31:0] rdata;
  } pcs_rsp_t;
  // Error events, one-cycle pulses tagged with a function number
  typedef struct packed {
    logic [2:0] func;
    logic       poisoned_rx;
    logic       serr;
    logic       ur_cpl_rx;
    logic       ca_cpl_rx;
    logic       ca_cpl_tx;
    logic       master_perr;
  } pcs_evt_t;
  // Per-function status fed from the link core
  typedef struct packed {
    logic [15:0]  dev_status;
    logic [15:0]  link_status;
    logic [31:0]  unc_err;
    logic [31:0]  cor_err;
    logic [127:0] hdr_log;
  } pcs_fstat_t;
  // Writable state of the space
  typedef struct packed {
    logic [15:0] cmd;
    logic [31:0] bar0;
    logic [7:0]  int_line;
    logic [1:0]  pm_state;
    logic        msi_en;
    logic [31:0] msi_alo;
    logic [31:0] msi_ahi;
    logic [15:0] msi_data;
    logic        msix_en;
    logic        msix_fmask;
    logic [7:0]  pcie_next;
    logic [31:0] imask;
    logic [31:0] retry_ctl;
  } pcs_regs_t;
endpackage

// ### design/pcs_status_bank.sv
// Sticky error bits of the legacy status register
`include "pcs_regs.svh"
module pcs_status_bank (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire pcs_pkg::pcs_evt_t evt_i,
  input  wire logic              func_en_i,
  input  wire logic [15:0]       clr_i,
  output      logic [15:0]       status_o
);
  logic [15:0] stat_d;
  logic [15:0] stat_q;
  logic        mine;

  // ==========================================================
  // Set and clear
  // Set is applied after clear so a same-cycle event survives
  always_comb begin
    mine   = func_en_i && (evt_i.func == 3'h0);
    stat_d = stat_q & ~(clr_i & `PCS_ST_W1C_MASK);
    if (mine && evt_i.poisoned_rx) stat_d[`PCS_ST_DPE] = 1'b1;
    if (mine && evt_i.serr) stat_d[`PCS_ST_SSE] = 1'b1;
    if (mine && evt_i.ur_cpl_rx) stat_d[`PCS_ST_RMA] = 1'b1;
    if (mine && evt_i.ca_cpl_rx) stat_d[`PCS_ST_RTA] = 1'b1;
    if (mine && evt_i.ca_cpl_tx) stat_d[`PCS_ST_STA] = 1'b1;
    if (mine && evt_i.master_perr) stat_d[`PCS_ST_MDPE] = 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) stat_q <= 16'h0000;
    else stat_q <= stat_d;
  end
  assign status_o = stat_q;

  // ==========================================================
  // Checks
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  dpe_set_a: assert property (func_en_i && evt_i.func == 3'h0 && evt_i.poisoned_rx
    |=> stat_q[15]) else $error("poisoned tlp not recorded");
  sse_set_a: assert property (func_en_i && evt_i.func == 3'h0 && evt_i.serr
    |=> stat_q[14]) else $error("serr not recorded");
  rma_set_a: assert property (func_en_i && evt_i.func == 3'h0 && evt_i.ur_cpl_rx
    |=> stat_q[13]) else $error("ur completion not recorded");
  rta_set_a: assert property (func_en_i && evt_i.func == 3'h0 && evt_i.ca_cpl_rx
    |=> stat_q[12]) else $error("received abort not recorded");
  sta_set_a: assert property (func_en_i && evt_i.func == 3'h0 && evt_i.ca_cpl_tx
    |=> stat_q[11]) else $error("signaled abort not recorded");
  mdpe_own_a: assert property ($rose(stat_q[8]) |->
    $past(func_en_i && evt_i.func == 3'h0 && evt_i.master_perr))
    else $error("parity bit set without own event");
  clear_one_a: assert property (stat_q[12] && clr_i[12] && !evt_i.ca_cpl_rx
    |=> !stat_q[12]) else $error("write one did not clear");
endmodule

// ### design/pcs_config_space.sv
// Configuration space of a single-function endpoint, two access ports
// How it works
// - Poisoned TLP for function zero sets status bit 15.
// - System error signalled by the function sets status bit 14.
// - Unsupported Request completion received sets status bit 13.
// - Completer Abort completion received sets status bit 12.
// - Completer Abort completion sent sets status bit 11.
// - Master data parity error sets bit 8 of its own function only.
// - Per-function link, device, error status and header logs read only when enabled.
// - Endpoint only; no root-complex mode exists.
// - Space is 4096 bytes: 256 legacy bytes then extended region.
// - Lowest 64 bytes form a standard type-0 header.
// - Both ports address 32-bit words; link writes honour byte enables, bus writes are whole words.
// - Only Type 0 requests to function zero are decoded.
// - Capabilities sit at 90H, 98H, A0H, B0H and D0H.
// - Status shows the capability-list bit; pointer names first capability.
// - Power management at 98H, control at 9CH, next pointer D0H.
// - MSI-X at B0H, locators at B4H and B8H, next pointer A0H.
// - MSI at A0H, address A4H, A8H, data ACH, next D0H.
// - PCIe capability next pointer resets to 00H, software may write 90H.
// - Offsets 000H to 0FFH reachable from both link and internal bus.
`include "pcs_regs.svh"
module pcs_config_space #(
  parameter logic [15:0] VENDOR_ID     = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID     = 16'h5678, // Arbitrary value
  parameter logic [7:0]  REVISION_ID   = 8'h01,    // Arbitrary value
  parameter logic [23:0] CLASS_CODE    = 24'h0b4000,
  parameter int          BAR0_SIZE_LOG2 = 20,
  parameter logic [15:0] PM_CAPS       = 16'h0002,
  parameter logic [10:0] MSIX_TBL_SIZE = 11'h007,
  parameter logic [31:0] MSIX_TBL_LOC  = 32'h0000_2000,
  parameter logic [31:0] MSIX_PEND_LOC = 32'h0000_3000
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire pcs_pkg::pcs_cfg_req_t cfg_req_i,
  output      pcs_pkg::pcs_rsp_t     cfg_rsp_o,
  input  wire pcs_pkg::pcs_ib_req_t  ib_req_i,
  output      pcs_pkg::pcs_rsp_t     ib_rsp_o,
  input  wire pcs_pkg::pcs_evt_t     evt_i,
  input  wire logic                  func_en_i,
  input  wire pcs_pkg::pcs_fstat_t   fstat_i,
  output      logic [15:0]           status_o,
  output      logic [15:0]           cmd_o,
  output      logic [1:0]            pm_state_o,
  output      logic                  msi_en_o,
  output      logic                  msix_en_o,
  output      logic                  pst_mask_o,
  output      logic                  cfg_retry_o
);
  localparam logic [31:0] BAR_MASK = ~((32'h1 << BAR0_SIZE_LOG2) - 32'h1);

  logic [1:0]         rst_sync_q;
  logic               rst_n;
  pcs_pkg::pcs_regs_t regs_d;
  pcs_pkg::pcs_regs_t regs_q;
  pcs_pkg::pcs_rsp_t  cfg_rsp_d;
  pcs_pkg::pcs_rsp_t  cfg_rsp_q;
  pcs_pkg::pcs_rsp_t  ib_rsp_d;
  pcs_pkg::pcs_rsp_t  ib_rsp_q;
  logic [15:0]        err_bits;
  logic [15:0]        stat_clr;
  logic               cfg_mine;
  logic               cfg_ok;

  // ==========================================================
  // Reset release
  // Async assert, release aligned to the clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [31:0] m);
    mrg = (o & ~m) | (d & m);
  endfunction

  // Byte-lane write of one word; local registers only from the bus
  function automatic pcs_pkg::pcs_regs_t wr(input pcs_pkg::pcs_regs_t r,
      input logic [11:0] off, input logic [31:0] d, input logic [3:0] be,
      input logic ib);
    logic [31:0] m;
    logic [31:0] t;
    m = lanes(be);
    t = 32'h0;
    case (off)
      `PCS_OFF_CMD: begin
        t = mrg({16'h0000, r.cmd}, d, m);
        r.cmd = t[15:0] & `PCS_CMD_WMASK;
      end
      `PCS_OFF_BAR0: r.bar0 = mrg(r.bar0, d, m) & BAR_MASK;
      `PCS_OFF_INTR: begin
        t = mrg({24'h0, r.int_line}, d, m);
        r.int_line = t[7:0];
      end
      `PCS_OFF_PM_CSR: begin
        t = mrg({30'h0, r.pm_state}, d, m);
        r.pm_state = t[1:0];
      end
      `PCS_OFF_MSI_HDR: begin
        t = mrg({15'h0, r.msi_en, 16'h0}, d, m);
        r.msi_en = t[16];
      end
      `PCS_OFF_MSI_ALO: r.msi_alo = mrg(r.msi_alo, d, m) & 32'hffff_fffc;
      `PCS_OFF_MSI_AHI: r.msi_ahi = mrg(r.msi_ahi, d, m);
      `PCS_OFF_MSI_DATA: begin
        t = mrg({16'h0, r.msi_data}, d, m);
        r.msi_data = t[15:0];
      end
      `PCS_OFF_MSIX_HDR: begin
        t = mrg({r.msix_en, r.msix_fmask, 30'h0}, d, m);
        r.msix_en = t[31];
        r.msix_fmask = t[30];
      end
      `PCS_OFF_PCIE_HDR: begin
        t = mrg({16'h0, r.pcie_next, 8'h0}, d, m);
        r.pcie_next = t[15:8];
      end
      `PCS_OFF_IMASK: if (ib) r.imask = d;
      `PCS_OFF_RETRY_CTL: if (ib) r.retry_ctl = d;
      default: r = r;
    endcase
    return r;
  endfunction

  // Read of one word; the whole 4096-byte space decodes, holes read zero
  function automatic logic [31:0] rd(input pcs_pkg::pcs_regs_t r,
      input logic [15:0] st, input logic [11:0] off, input logic ib);
    logic [31:0] v;
    v = 32'h0;
    case (off)
      `PCS_OFF_ID:     v = {DEVICE_ID, VENDOR_ID};
      `PCS_OFF_CMD:    v = {st, r.cmd};
      `PCS_OFF_CLASS:  v = {CLASS_CODE, REVISION_ID};
      `PCS_OFF_MISC:   v = {8'h00, `PCS_HDR_TYPE0, 16'h0000};
      `PCS_OFF_BAR0:   v = r.bar0;
      `PCS_OFF_CAPPTR: v = {24'h0, `PCS_CAP_PTR};
      `PCS_OFF_INTR:   v = {16'h0000, 8'h01, r.int_line};
      `PCS_OFF_VPD:    v = {16'h0000, `PCS_VPD_NEXT, `PCS_ID_VPD};
      `PCS_OFF_PM_HDR: v = {PM_CAPS, `PCS_PM_NEXT, `PCS_ID_PM};
      `PCS_OFF_PM_CSR: v = {30'h0, r.pm_state};
      `PCS_OFF_MSI_HDR: v = {15'h0040, r.msi_en, `PCS_MSI_NEXT, `PCS_ID_MSI};
      `PCS_OFF_MSI_ALO: v = r.msi_alo;
      `PCS_OFF_MSI_AHI: v = r.msi_ahi;
      `PCS_OFF_MSI_DATA: v = {16'h0000, r.msi_data};
      `PCS_OFF_MSIX_HDR: v = {r.msix_en, r.msix_fmask, 3'h0, MSIX_TBL_SIZE,
                              `PCS_MSIX_NEXT, `PCS_ID_MSIX};
      `PCS_OFF_MSIX_TBL: v = MSIX_TBL_LOC;
      `PCS_OFF_MSIX_PEND: v = MSIX_PEND_LOC;
      `PCS_OFF_PCIE_HDR: v = {`PCS_PCIE_CAPS, r.pcie_next, `PCS_ID_PCIE};
      `PCS_OFF_PCIE_DEV: v = func_en_i ? {fstat_i.dev_status, 16'h0} : 32'h0;
      `PCS_OFF_PCIE_LNK: v = func_en_i ? {fstat_i.link_status, 16'h0} : 32'h0;
      `PCS_OFF_AER_UNC:  v = func_en_i ? fstat_i.unc_err : 32'h0;
      `PCS_OFF_AER_COR:  v = func_en_i ? fstat_i.cor_err : 32'h0;
      `PCS_OFF_AER_LOG0: v = func_en_i ? fstat_i.hdr_log[31:0] : 32'h0;
      `PCS_OFF_AER_LOG1: v = func_en_i ? fstat_i.hdr_log[63:32] : 32'h0;
      `PCS_OFF_AER_LOG2: v = func_en_i ? fstat_i.hdr_log[95:64] : 32'h0;
      `PCS_OFF_AER_LOG3: v = func_en_i ? fstat_i.hdr_log[127:96] : 32'h0;
      `PCS_OFF_IMASK:  v = ib ? r.imask : 32'h0;
      `PCS_OFF_RETRY_CTL: v = ib ? r.retry_ctl : 32'h0;
      default:         v = 32'h0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Request decode
  // Retry holds the host off until local setup is finished
  assign cfg_mine = cfg_req_i.type0 && (cfg_req_i.func == 3'h0);
  assign cfg_ok   = cfg_req_i.valid && cfg_mine && !regs_q.retry_ctl[`PCS_RETRY_BIT];

  // Write-one-to-clear strobes for the sticky error bits
  always_comb begin
    stat_clr = 16'h0000;
    if (cfg_ok && cfg_req_i.write && cfg_req_i.offset == `PCS_OFF_CMD)
      stat_clr = cfg_req_i.wdata[31:16] & {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}}};
    if (ib_req_i.valid && ib_req_i.write && ib_req_i.offset == `PCS_OFF_CMD)
      stat_clr = stat_clr | ib_req_i.wdata[31:16];
  end

  pcs_status_bank pcs_status_bank_inst (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n),
    .evt_i     (evt_i),
    .func_en_i (func_en_i),
    .clr_i     (stat_clr),
    .status_o  (err_bits)
  );

  // ==========================================================
  // Register state
  // Link write first, bus write second: the bus wins a same-word clash
  always_comb begin
    regs_d = regs_q;
    if (cfg_ok && cfg_req_i.write)
      regs_d = wr(regs_d, cfg_req_i.offset, cfg_req_i.wdata, cfg_req_i.be, 1'b0);
    if (ib_req_i.valid && ib_req_i.write)
      regs_d = wr(regs_d, ib_req_i.offset, ib_req_i.wdata, 4'hf, 1'b1);
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      regs_q           <= '0;
      regs_q.pcie_next <= `PCS_PCIE_NEXT_RST;
      regs_q.imask     <= `PCS_IMASK_RST;
      regs_q.retry_ctl <= `PCS_RETRY_CTL_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ==========================================================
  // Answers, one cycle after the request
  always_comb begin
    cfg_rsp_d       = '0;
    cfg_rsp_d.valid = cfg_req_i.valid;
    cfg_rsp_d.unsup = cfg_req_i.valid && !cfg_mine;
    cfg_rsp_d.retry = cfg_req_i.valid && cfg_mine && regs_q.retry_ctl[`PCS_RETRY_BIT];
    if (cfg_ok && !cfg_req_i.write)
      cfg_rsp_d.rdata = rd(regs_q, status_word(err_bits), cfg_req_i.offset, 1'b0);
    ib_rsp_d        = '0;
    ib_rsp_d.valid  = ib_req_i.valid;
    if (ib_req_i.valid && !ib_req_i.write)
      ib_rsp_d.rdata = rd(regs_q, status_word(err_bits), ib_req_i.offset, 1'b1);
  end

  function automatic logic [15:0] status_word(input logic [15:0] e);
    status_word = (e & `PCS_ST_W1C_MASK) | (16'h1 << `PCS_ST_CAPL);
  endfunction

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp_q <= '0;
      ib_rsp_q  <= '0;
    end else begin
      cfg_rsp_q <= cfg_rsp_d;
      ib_rsp_q  <= ib_rsp_d;
    end
  end

  // Outputs straight from flip-flops
  assign cfg_rsp_o   = cfg_rsp_q;
  assign ib_rsp_o    = ib_rsp_q;
  assign status_o    = err_bits;
  assign cmd_o       = regs_q.cmd;
  assign pm_state_o  = regs_q.pm_state;
  assign msi_en_o    = regs_q.msi_en;
  assign msix_en_o   = regs_q.msix_en;
  assign pst_mask_o  = regs_q.imask[`PCS_IMASK_PST];
  assign cfg_retry_o = regs_q.retry_ctl[`PCS_RETRY_BIT];

  // ==========================================================
  // Checks
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_n);
  unsup_answer_a: assert property (cfg_req_i.valid && !cfg_mine
    |=> cfg_rsp_o.valid && cfg_rsp_o.unsup && cfg_rsp_o.rdata == 32'h0)
    else $error("foreign request not refused");
  retry_answer_a: assert property (cfg_req_i.valid && cfg_mine && cfg_retry_o
    |=> cfg_rsp_o.retry && cfg_rsp_o.rdata == 32'h0)
    else $error("request not retried");
  pm_chain_a: assert property (ib_req_i.valid && !ib_req_i.write
    && ib_req_i.offset == 12'h098 |=> ib_rsp_o.rdata[15:0] == 16'hd001)
    else $error("power header wrong");
  msix_chain_a: assert property (ib_req_i.valid && !ib_req_i.write
    && ib_req_i.offset == 12'h0b0 |=> ib_rsp_o.rdata[15:8] == 8'ha0)
    else $error("msix next pointer wrong");
  msi_chain_a: assert property (cfg_ok && !cfg_req_i.write
    && cfg_req_i.offset == 12'h0a0 |=> cfg_rsp_o.rdata[15:8] == 8'hd0)
    else $error("msi next pointer wrong");
  capl_bit_a: assert property (ib_req_i.valid && !ib_req_i.write
    && ib_req_i.offset == 12'h004 |=> ib_rsp_o.rdata[20])
    else $error("capability list bit clear");
  pcie_next_a: assert property ($rose(rst_n) |-> regs_q.pcie_next == 8'h00)
    else $error("pcie next pointer reset wrong");
  // Mirrors hide while the function is off; link writes never reach local state
  mirror_gate_a: assert property (cfg_ok && !cfg_req_i.write && !func_en_i
    && cfg_req_i.offset == `PCS_OFF_AER_UNC |=> cfg_rsp_o.rdata == 32'h0)
    else $error("disabled function status visible");
  retry_hold_a: assert property (cfg_req_i.valid && cfg_req_i.write && cfg_retry_o
    && !ib_req_i.valid |=> $stable(pm_state_o) && $stable(cmd_o))
    else $error("retried write took effect");
  link_local_a: assert property (cfg_req_i.valid && cfg_req_i.write && !ib_req_i.valid
    && cfg_req_i.offset == `PCS_OFF_IMASK |=> $stable(pst_mask_o))
    else $error("link write reached interrupt mask");
  hole_zero_a: assert property (ib_req_i.valid && !ib_req_i.write
    && ib_req_i.offset == 12'h200 |=> ib_rsp_o.rdata == 32'h0)
    else $error("unmapped word not zero");
  cov_cfg_write: cover property (cfg_ok && cfg_req_i.write);
  cov_msix_en: cover property ($rose(msix_en_o));
  cov_retry: cover property (cfg_rsp_o.retry);
  cov_err_set: cover property ($rose(err_bits[15]));
endmodule

// ### tb/pcs_host_model.sv
// Host-side model that issues configuration requests to the space
module pcs_host_model (
  input  wire logic              clock_i,
  input  wire pcs_pkg::pcs_rsp_t cfg_rsp_i,
  output pcs_pkg::pcs_cfg_req_t  cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Request driver
  // Idle until the first request
  initial cfg_req_o = '0;

  // One request; the answer is awaited for a bounded number of cycles
  task automatic xfer(input logic wr, input logic t0, input logic [2:0] fn,
                      input logic [11:0] off, input logic [3:0] be,
                      input logic [31:0] wd, output pcs_pkg::pcs_rsp_t rsp,
                      output logic got);
    got = 1'b0;
    rsp = '0;
    @(posedge clock_i);
    cfg_req_o <= '{1'b1, wr, t0, fn, off, be, wd};
    @(posedge clock_i);
    cfg_req_o.valid <= 1'b0;
    cfg_req_o.wdata <= ~wd; // Stale data must not look valid
    for (int i = 0; i < 4 && !got; i++) begin
      #1;
      if (cfg_rsp_i.valid === 1'b1) begin
        rsp = cfg_rsp_i;
        got = 1'b1;
      end else begin
        @(posedge clock_i);
      end
    end
  endtask
endmodule

// ### tb/pcie_config_space_status_tb.sv
// Self-checking bench of the configuration space
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module pcie_config_space_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] off;
    logic [31:0] exp;
  } pcs_row_t;

  logic                  clock_i;
  logic                  rst_n_i;
  pcs_pkg::pcs_cfg_req_t cfg_req;
  pcs_pkg::pcs_rsp_t     cfg_rsp;
  pcs_pkg::pcs_ib_req_t  ib_req_i;
  pcs_pkg::pcs_rsp_t     ib_rsp_o;
  pcs_pkg::pcs_evt_t     evt_i;
  logic                  func_en_i;
  pcs_pkg::pcs_fstat_t   fstat_i;
  logic [15:0]           status_o;
  logic [15:0]           cmd_o;
  logic [1:0]            pm_state_o;
  logic                  msi_en_o;
  logic                  msix_en_o;
  logic                  pst_mask_o;
  logic                  cfg_retry_o;
  pcs_pkg::pcs_rsp_t     rsp;
  logic [31:0]           rd;
  int                    errors = 0;
  int                    checked = 0;
  int                    pos [6] = '{15, 14, 13, 12, 11, 8};
  pcs_row_t              rows [11] = '{
    '{12'h000, 32'h5678_1234}, '{12'h004, 32'h0010_0000}, '{12'h034, 32'h0000_0098},
    '{12'h090, 32'h0000_0003}, '{12'h098, 32'h0002_d001}, '{12'h0a0, 32'h0080_d005},
    '{12'h0b0, 32'h0007_a011}, '{12'h0b4, 32'h0000_2000}, '{12'h0b8, 32'h0000_3000},
    '{12'h0d0, 32'h0001_0010}, '{12'h200, 32'h0000_0000}};

  // ==========================================================
  // Design and host
  pcs_config_space pcs_config_space_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req), .cfg_rsp_o(cfg_rsp),
    .ib_req_i(ib_req_i), .ib_rsp_o(ib_rsp_o), .evt_i(evt_i), .func_en_i(func_en_i),
    .fstat_i(fstat_i), .status_o(status_o), .cmd_o(cmd_o), .pm_state_o(pm_state_o),
    .msi_en_o(msi_en_o), .msix_en_o(msix_en_o), .pst_mask_o(pst_mask_o),
    .cfg_retry_o(cfg_retry_o));
  pcs_host_model pcs_host_model_inst (
    .clock_i(clock_i), .cfg_rsp_i(cfg_rsp), .cfg_req_o(cfg_req));

  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // ==========================================================
  // Tasks
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Host request; a lost answer ends the run
  task automatic cfg(input logic wr, input logic t0, input logic [2:0] fn,
                     input logic [11:0] off, input logic [3:0] be, input logic [31:0] wd);
    logic got;
    pcs_host_model_inst.xfer(wr, t0, fn, off, be, wd, rsp, got);
    if (!got) begin
      errors++;
      finish_test();
    end
  endtask

  // Local core word access on the internal bus
  task automatic ib(input logic wr, input logic [11:0] off, input logic [31:0] wd);
    logic got;
    got = 1'b0;
    @(posedge clock_i);
    ib_req_i <= '{1'b1, wr, off, wd};
    @(posedge clock_i);
    ib_req_i.valid <= 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      #1;
      if (ib_rsp_o.valid === 1'b1) begin
        rd = ib_rsp_o.rdata;
        got = 1'b1;
      end else begin
        @(posedge clock_i);
      end
    end
    if (!got) begin
      errors++;
      finish_test();
    end
  endtask

  // One-cycle error event pulse
  task automatic ev(input logic [5:0] bits, input logic [2:0] fn);
    @(posedge clock_i);
    evt_i <= {fn, bits};
    @(posedge clock_i);
    evt_i <= '0;
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    ib_req_i = '0;
    evt_i = '0;
    func_en_i = 1'b1;
    fstat_i = '{16'h00a5, 16'h1011, 32'h0001_0010, 32'h0000_2001,
                {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111}};
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(({cfg_retry_o, pst_mask_o, status_o}), 18'h3_0000)
    cfg(1'b0, 1'b1, 3'h0, 12'h098, 4'hf, 32'h0);
    `CHK(({rsp.retry, rsp.rdata}), 33'h1_0000_0000)
    ib(1'b1, 12'h180, 32'h0);
    `CHK(pst_mask_o, 1'b0)
    ib(1'b1, 12'h188, 32'h0);
    `CHK(cfg_retry_o, 1'b0)
    // Table rows through both ports
    foreach (rows[i]) begin
      cfg(1'b0, 1'b1, 3'h0, rows[i].off, 4'hf, 32'h0);
      `CHK(rsp.rdata, rows[i].exp)
      ib(1'b0, rows[i].off, 32'h0);
      `CHK(rd, rows[i].exp)
    end
    // Each event on its own function, then another function, then clear
    foreach (pos[i]) begin
      ev(6'h20 >> i, 3'h0);
      `CHK(status_o, 16'h1 << pos[i])
      ev(6'h20 >> i, 3'h1);
      `CHK(status_o, 16'h1 << pos[i])
      cfg(1'b0, 1'b1, 3'h0, 12'h004, 4'hf, 32'h0);
      `CHK(rsp.rdata, 32'h0010_0000 | (32'h1 << (pos[i] + 16)))
      cfg(1'b1, 1'b1, 3'h0, 12'h004, 4'hc, 32'h1 << (pos[i] + 16));
      `CHK(status_o, 16'h0000)
    end
    // Per-function mirrors, then disabled function
    cfg(1'b0, 1'b1, 3'h0, 12'h0d8, 4'hf, 32'h0);
    `CHK(rsp.rdata[31:16], 16'h00a5)
    cfg(1'b0, 1'b1, 3'h0, 12'h0e0, 4'hf, 32'h0);
    `CHK(rsp.rdata[31:16], 16'h1011)
    cfg(1'b0, 1'b1, 3'h0, 12'h104, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h0001_0010)
    cfg(1'b0, 1'b1, 3'h0, 12'h110, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h0000_2001)
    for (int w = 0; w < 4; w++) begin
      cfg(1'b0, 1'b1, 3'h0, 12'h11c + 12'(4 * w), 4'hf, 32'h0);
      `CHK(rsp.rdata, fstat_i.hdr_log[32 * w +: 32])
    end
    func_en_i <= 1'b0;
    ev(6'h3f, 3'h0);
    `CHK(status_o, 16'h0000)
    cfg(1'b0, 1'b1, 3'h0, 12'h104, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h0)
    func_en_i <= 1'b1;
    // Refused requests
    cfg(1'b0, 1'b0, 3'h0, 12'h098, 4'hf, 32'h0);
    `CHK(({rsp.unsup, rsp.rdata}), 33'h1_0000_0000)
    cfg(1'b1, 1'b1, 3'h1, 12'h09c, 4'hf, 32'h3);
    `CHK(({rsp.unsup, pm_state_o}), 3'h4)
    cfg(1'b1, 1'b1, 3'h0, 12'h180, 4'hf, 32'h100);
    `CHK(pst_mask_o, 1'b0)
    // Writable fields
    cfg(1'b1, 1'b1, 3'h0, 12'h0d0, 4'h2, 32'h0000_9000);
    cfg(1'b0, 1'b1, 3'h0, 12'h0d0, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h0001_9010)
    cfg(1'b1, 1'b1, 3'h0, 12'h09c, 4'h1, 32'h3);
    `CHK(pm_state_o, 2'h3)
    cfg(1'b1, 1'b1, 3'h0, 12'h0a0, 4'h4, 32'h0001_0000);
    `CHK(msi_en_o, 1'b1)
    cfg(1'b1, 1'b1, 3'h0, 12'h0b0, 4'h8, 32'h8000_0000);
    `CHK(msix_en_o, 1'b1)
    cfg(1'b1, 1'b1, 3'h0, 12'h0b0, 4'h8, 32'h4000_0000);
    ib(1'b0, 12'h0b0, 32'h0);
    `CHK(rd, 32'h4007_a011)
    cfg(1'b1, 1'b1, 3'h0, 12'h010, 4'hf, 32'hffff_ffff);
    ib(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'hfff0_0000)
    cfg(1'b1, 1'b1, 3'h0, 12'h03c, 4'h1, 32'h0000_005a);
    ib(1'b0, 12'h03c, 32'h0);
    `CHK(rd, 32'h0000_015a)
    ib(1'b1, 12'h0a4, 32'h1234_5678);
    cfg(1'b0, 1'b1, 3'h0, 12'h0a4, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h1234_5678)
    ib(1'b1, 12'h0ac, 32'hffff_beef);
    cfg(1'b0, 1'b1, 3'h0, 12'h0ac, 4'hf, 32'h0);
    `CHK(rsp.rdata, 32'h0000_beef)
    cfg(1'b1, 1'b1, 3'h0, 12'h004, 4'h3, 32'h0000_ffff);
    `CHK(cmd_o, 16'h0547)
    // Reset in mid-run brings back the locked state; a link write is retried
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(({cfg_retry_o, pst_mask_o, msi_en_o, pm_state_o, cmd_o}), 21'h18_0000)
    cfg(1'b1, 1'b1, 3'h0, 12'h09c, 4'hf, 32'h3);
    `CHK(({rsp.retry, pm_state_o}), 3'h4)
    finish_test();
  end
endmodule
